// ### hdl/adc_sw_trigger_wait_seq_ctrl.sv
// sequencer of the converter in software-trigger wait, select, sequential mode
`timescale 1ns/10ps
`default_nettype none
module adc_sw_trigger_wait_seq_ctrl
    import adc_seq_pkg::*;
#(
    parameter int chan_width  = 3,
    parameter int data_width  = 12,
    parameter int conv_cycles = conv_cycles_default,
    parameter int stab_cycles = stab_cycles_default,
    parameter int fad_div     = fad_div_default
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic [3:0]            addr,
    input  wire logic [15:0]           wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic [15:0]                rdata,
    input  wire logic                  hw_trigger,
    input  wire logic [data_width-1:0] sample_data,
    output logic [chan_width-1:0]      sample_channel,
    output logic                       sampling,
    output logic                       conversion_end_irq,
    output logic                       irq
);
    localparam int cw = 8;

    // registers
    logic                   conversion_start_bit_reg, conversion_start_bit_next;
    logic                   comparator_enable_bit_reg, comparator_enable_bit_next;
    logic [chan_width-1:0]  channel_select_register_reg, channel_select_register_next;
    logic [data_width-1:0]  result_register_full_reg, result_register_full_next;
    logic [1:0]             status_reg, status_next;
    logic [1:0]             enable_reg, enable_next;
    logic [15:0]            rdata_reg, rdata_next;
    logic                   end_pulse_reg, end_pulse_next;
    seq_state_type          state_reg, state_next;
    logic [7:0]             div_reg, div_next;
    logic                   trig_meta_reg, trig_sync_reg;

    logic       fad_tick;
    logic       core_clear;
    logic       core_done;
    logic [cw-1:0] core_target;
    logic       ctrl_wr, chan_wr, abort_restart, ev_end, ev_abort;

    function automatic logic [cw-1:0] to_cnt(input int n);
        to_cnt = cw'(n);
    endfunction

    assign ctrl_wr = wr && (addr == ctrl_addr);
    assign chan_wr = wr && (addr == chan_addr);
    assign fad_tick = (div_reg == 8'(fad_div - 1));

    // hardware trigger is synchronised but only observed, never acted on here
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
        end else if (ce) begin
            trig_meta_reg <= hw_trigger;
            trig_sync_reg <= trig_meta_reg;
        end
    end

    adc_conv_core #(
        .cnt_width (cw)
    ) u_core (
        .mclk      (mclk),
        .resetn    (resetn),
        .ce        (ce),
        .fad_tick  (fad_tick),
        .clear     (core_clear),
        .target    (core_target),
        .done      (core_done)
    );

    // restart on start rewrite or any channel write while busy
    assign abort_restart = (state_reg != st_stop) && comparator_enable_bit_reg &&
                           ((ctrl_wr && wdata[ctrl_start_pos]) || chan_wr); // [R5] [R6]

    always_comb begin
        state_next  = state_reg;
        core_clear  = 1'b0;
        core_target = to_cnt(conv_cycles);
        ev_end      = 1'b0;
        ev_abort    = 1'b0;
        unique case (state_reg)
            st_stop: begin
                core_clear = 1'b1;
                // starting needs the comparator enabled; software parks it at 0 first [R1]
                if (conversion_start_bit_next && comparator_enable_bit_reg) begin
                    state_next = st_stab; // [R2]
                end
            end
            st_rearm: begin
                core_clear = 1'b1;
                // wait for next conversion clock edge before the stabilization wait [R9]
                if (fad_tick) begin
                    state_next = st_stab;
                end
            end
            st_stab: begin
                core_target = to_cnt(stab_cycles);
                if (core_done) begin
                    core_clear = 1'b1;
                    state_next = st_conv; // [R9]
                end
            end
            st_conv: begin
                if (core_done) begin
                    core_clear = 1'b1;
                    ev_end     = 1'b1; // [R3]
                    state_next = st_conv; // [R4]
                end
            end
        endcase
        // hw_trigger never enters this decision [R7]
        if (state_reg != st_stop) begin
            if (!conversion_start_bit_next || !comparator_enable_bit_next) begin
                state_next = st_stop; // [R8]
                core_clear = 1'b1;
                ev_abort   = 1'b1;
                ev_end     = 1'b0;
            end else if (abort_restart) begin
                state_next = st_rearm; // [R5] [R6]
                core_clear = 1'b1;
                ev_abort   = 1'b1;
                ev_end     = 1'b0;
            end
        end
    end

    always_comb begin
        conversion_start_bit_next    = conversion_start_bit_reg;
        comparator_enable_bit_next   = comparator_enable_bit_reg;
        channel_select_register_next = channel_select_register_reg;
        result_register_full_next    = result_register_full_reg;
        div_next                     = fad_tick ? 8'h00 : div_reg + 8'h01;
        end_pulse_next               = 1'b0;
        if (ctrl_wr) begin
            conversion_start_bit_next  = wdata[ctrl_start_pos];
            comparator_enable_bit_next = wdata[ctrl_enable_pos];
        end
        if (chan_wr) begin
            channel_select_register_next = wdata[chan_width-1:0];
        end
        if (ev_end) begin
            result_register_full_next = sample_data; // [R3] [R10]
            end_pulse_next            = 1'b1;
        end
    end

    // sticky status: a set in the same cycle as a clear wins
    always_comb begin
        status_next = status_reg;
        enable_next = enable_reg;
        if (wr && addr == irq_clear_addr) begin
            status_next = status_reg & ~wdata[1:0];
        end
        if (wr && addr == irq_enable_addr) begin
            enable_next = wdata[1:0];
        end
        if (ev_end) begin
            status_next[irq_end_pos] = 1'b1;
        end
        if (ev_abort) begin
            status_next[irq_abort_pos] = 1'b1;
        end
    end

    always_comb begin
        rdata_next = 16'h0000;
        if (rd) begin
            unique case (addr)
                ctrl_addr:       rdata_next = {14'h0000, comparator_enable_bit_reg, conversion_start_bit_reg};
                chan_addr:       rdata_next = 16'(channel_select_register_reg);
                result_addr:     rdata_next = 16'(result_register_full_reg);
                status_addr:     rdata_next = {10'h000, state_reg, status_reg};
                irq_enable_addr: rdata_next = {14'h0000, enable_reg};
                default:         rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            conversion_start_bit_reg    <= ctrl_reset[ctrl_start_pos];
            comparator_enable_bit_reg   <= ctrl_reset[ctrl_enable_pos];
            channel_select_register_reg <= '0;
            result_register_full_reg    <= '0;
            status_reg                  <= 2'h0;
            enable_reg                  <= 2'h0;
            rdata_reg                   <= 16'h0000;
            end_pulse_reg               <= 1'b0;
            state_reg                   <= st_stop;
            div_reg                     <= 8'h00;
        end else if (ce) begin
            conversion_start_bit_reg    <= conversion_start_bit_next;
            comparator_enable_bit_reg   <= comparator_enable_bit_next;
            channel_select_register_reg <= channel_select_register_next;
            result_register_full_reg    <= result_register_full_next;
            status_reg                  <= status_next;
            enable_reg                  <= enable_next;
            rdata_reg                   <= rdata_next;
            end_pulse_reg               <= end_pulse_next;
            state_reg                   <= state_next;
            div_reg                     <= div_next;
        end
    end

    assign rdata              = rdata_reg;
    assign sample_channel     = channel_select_register_reg;
    assign sampling           = (state_reg == st_conv);
    assign conversion_end_irq = end_pulse_reg;
    assign irq                = |(status_reg & enable_reg);

    // checks
    result_hold_a: assert property (@(posedge mclk) disable iff (!resetn) // [R10]
        (ce && !ev_end) |=> $stable(result_register_full_reg))
        else $error("result changed without completion");
    end_irq_a: assert property (@(posedge mclk) disable iff (!resetn) // [R3]
        (ce && ev_end) |=> conversion_end_irq && status_reg[irq_end_pos])
        else $error("end irq missing");
    restart_rearm_a: assert property (@(posedge mclk) disable iff (!resetn) // [R5]
        (ce && state_reg != st_stop && conversion_start_bit_next && comparator_enable_bit_next
         && ctrl_wr && wdata[ctrl_start_pos]) |=> state_reg == st_rearm)
        else $error("start rewrite did not restart");
    chan_restart_a: assert property (@(posedge mclk) disable iff (!resetn) // [R6]
        (ce && state_reg != st_stop && conversion_start_bit_reg && comparator_enable_bit_reg
         && chan_wr && !ctrl_wr) |=> state_reg == st_rearm)
        else $error("channel write did not restart");
    stop_clear_a: assert property (@(posedge mclk) disable iff (!resetn) // [R8]
        (ce && state_reg != st_stop && ctrl_wr && !wdata[ctrl_start_pos]) |=> state_reg == st_stop)
        else $error("start clear did not stop");
    stab_before_conv_a: assert property (@(posedge mclk) disable iff (!resetn) // [R9]
        (state_reg == st_conv && $past(state_reg) != st_conv) |-> $past(state_reg) == st_stab)
        else $error("conversion without stabilization");
    seq_continue_a: assert property (@(posedge mclk) disable iff (!resetn) // [R4]
        (ce && ev_end) |=> state_reg == st_conv)
        else $error("sequential conversion stopped");
    stop_start_a: assert property (@(posedge mclk) disable iff (!resetn) // [R2]
        (ce && state_reg == st_stop && ctrl_wr && wdata[ctrl_start_pos] && wdata[ctrl_enable_pos]
         && comparator_enable_bit_reg) |=> state_reg == st_stab)
        else $error("start from stop ignored");
    trig_ignored_a: assert property (@(posedge mclk) disable iff (!resetn) // [R7]
        (ce && state_reg == st_stop && !wr && trig_sync_reg) |=> state_reg == st_stop)
        else $error("hardware trigger acted");

    conv_done_c: cover property (@(posedge mclk) disable iff (!resetn) ev_end);
    restart_c:   cover property (@(posedge mclk) disable iff (!resetn) state_reg == st_rearm);
    stop_c:      cover property (@(posedge mclk) disable iff (!resetn) ev_abort && state_next == st_stop);
endmodule
`default_nettype wire

// ### hdl/adc_seq_pkg.sv
// constants and types shared by the converter sequencer
// What this block does
// [R1] software clears comparator enable to enter stop state before using this mode
// [R2] start bit written 1 in stop state begins converting the selected channel
// [R3] each finished conversion stores the result and raises conversion-end irq
// [R4] sequential mode restarts the same channel at once after each conversion
// [R5] start bit rewritten 1 mid-conversion aborts, discards partial data, restarts
// [R6] any channel select write mid-conversion aborts and converts the new channel
// [R7] hardware triggers are ignored while converting in this mode
// [R8] start bit cleared mid-conversion aborts and returns to stop state
// [R9] restart after abort waits stabilization time from next conversion clock edge
// [R10] result registers keep last completed value when a conversion aborts
package adc_seq_pkg;
    localparam logic [3:0] ctrl_addr       = 4'h0;
    localparam logic [3:0] chan_addr       = 4'h1;
    localparam logic [3:0] result_addr     = 4'h2;
    localparam logic [3:0] status_addr     = 4'h3;
    localparam logic [3:0] irq_clear_addr  = 4'h4;
    localparam logic [3:0] irq_enable_addr = 4'h5;
    localparam int         ctrl_start_pos  = 0;
    localparam int         ctrl_enable_pos = 1;
    localparam int         irq_end_pos     = 0;
    localparam int         irq_abort_pos   = 1;
    localparam logic [15:0] ctrl_reset     = 16'h0000;
    localparam logic [15:0] result_reset   = 16'h0000;
    localparam int         conv_cycles_default = 16;
    localparam int         stab_cycles_default = 8;
    localparam int         fad_div_default     = 2;

    typedef enum logic [3:0] {
        st_stop    = 4'b0001,
        st_stab    = 4'b0010,
        st_conv    = 4'b0100,
        st_rearm   = 4'b1000
    } seq_state_type;
endpackage

// ### hdl/adc_conv_core.sv
// conversion timer core: counts conversion clock ticks for one sample
`timescale 1ns/10ps
`default_nettype none
module adc_conv_core
    import adc_seq_pkg::*;
#(
    parameter int cnt_width = 8
) (
    input  wire logic                 mclk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    input  wire logic                 fad_tick,
    input  wire logic                 clear,
    input  wire logic [cnt_width-1:0] target,
    output logic                      done
);
    logic [cnt_width-1:0] count_reg;
    logic [cnt_width-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = '0;
        end else if (fad_tick && !done) begin
            count_next = count_reg + cnt_width'(1);
        end
    end

    assign done = (count_reg == target);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (ce) begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

// ### testbench/analog_front_model.sv
// behavioural analog front end: returns a channel-coded sample while converting
`timescale 1ns/10ps
`default_nettype none
module analog_front_model #(
    parameter int chan_width = 3,
    parameter int data_width = 12
) (
    input  wire logic                  mclk,
    input  wire logic [chan_width-1:0] sample_channel,
    input  wire logic                  sampling,
    output logic [data_width-1:0]      sample_data
);
    logic [data_width-1:0] noise_reg;

    initial noise_reg = '0;
    // outside the conversion phase the input is not valid, so it wanders every cycle
    always @(posedge mclk) begin
        noise_reg <= ~noise_reg ^ data_width'(3);
    end
    assign sample_data = sampling ? (data_width'(12'h5A0) | data_width'(sample_channel)) : noise_reg;
endmodule
`default_nettype wire

// ### testbench/adc_sw_trigger_wait_seq_ctrl_tb_top.sv
// self-checking bench of the converter sequencer in software-trigger wait mode
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module adc_sw_trigger_wait_seq_ctrl_tb_top;
    import adc_seq_pkg::*;
    localparam int conv_c = 4;
    localparam int stab_c = 4;
    localparam int div_c  = 2;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        hw_trigger = 1'b0;
    logic        ce = 1'b1;
    logic [15:0] rdata;
    logic [11:0] sample_data;
    logic [2:0]  sample_channel;
    logic        sampling;
    logic        conversion_end_irq;
    logic        irq;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          n;
    logic [15:0] d;

    always #25 mclk = ~mclk;

    adc_sw_trigger_wait_seq_ctrl #(.conv_cycles(conv_c), .stab_cycles(stab_c), .fad_div(div_c)) DUT (
        .mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .hw_trigger(hw_trigger), .sample_data(sample_data),
        .sample_channel(sample_channel), .sampling(sampling),
        .conversion_end_irq(conversion_end_irq), .irq(irq));

    analog_front_model front (.mclk(mclk), .sample_channel(sample_channel), .sampling(sampling),
        .sample_data(sample_data));

    function automatic logic [15:0] exp_data(input logic [2:0] ch);
        return 16'h05A0 | {13'h0000, ch};
    endfunction

    task automatic reg_write(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        v = rdata;
    endtask

    // cycles until the next end pulse; a bound keeps a stuck sequencer from hanging us
    task automatic wait_end(output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            cnt++;
        end while (conversion_end_irq !== 1'b1 && cnt < 200);
        if (cnt >= 200) begin
            `CHK(1'b0, 1'b1)
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        reg_read(ctrl_addr, d);    `CHK(d, ctrl_reset)
        reg_read(result_addr, d);  `CHK(d, result_reset)
        reg_read(status_addr, d);  `CHK(d, 16'h0004)
        reg_read(4'hF, d);         `CHK(d, 16'h0000)
        $display("test reset values done");

        reg_write(irq_enable_addr, 16'h0001);
        reg_write(chan_addr, 16'h0000);
        reg_write(ctrl_addr, 16'h0000);
        reg_write(ctrl_addr, 16'h0002);
        reg_write(ctrl_addr, 16'h0003);
        wait_end(n);               `CHK(sample_channel, 3'h0)
        reg_read(result_addr, d);  `CHK(d, exp_data(3'h0))
        `CHK(irq, 1'b1)
        wait_end(n);
        wait_end(n);               `CHK(n, conv_c * div_c)
        `CHK(sampling, 1'b1)
        // a low clock enable freezes the sequencer, so the period resumes where it stopped
        wait_end(n);
        ce <= 1'b0;
        repeat (30) @(posedge mclk);
        `CHK(conversion_end_irq, 1'b0)
        ce <= 1'b1;
        wait_end(n);               `CHK(n, conv_c * div_c)
        $display("test start and sequential done");

        // a rewrite of the start bit must pay the stabilization wait again
        wait_end(n);
        reg_write(ctrl_addr, 16'h0003);
        wait_end(n);               `CHK(n >= (stab_c + conv_c) * div_c - 2, 1'b1)
        wait_end(n);
        reg_write(chan_addr, 16'h0005);
        reg_read(result_addr, d);  `CHK(d, exp_data(3'h0))
        wait_end(n);               `CHK(n >= (stab_c + conv_c) * div_c - 5, 1'b1)
        `CHK(sample_channel, 3'h5)
        reg_read(result_addr, d);  `CHK(d, exp_data(3'h5))
        $display("test restarts done");

        wait_end(n);
        hw_trigger <= 1'b1;
        repeat (3) @(posedge mclk);
        hw_trigger <= 1'b0;
        wait_end(n);               `CHK(n < (stab_c + conv_c) * div_c - 3, 1'b1)
        wait_end(n);
        reg_write(ctrl_addr, 16'h0002);
        repeat (40) @(posedge mclk);
        reg_read(status_addr, d);  `CHK(d & 16'h003E, 16'h0006)
        reg_read(result_addr, d);  `CHK(d, exp_data(3'h5))
        hw_trigger <= 1'b1;
        repeat (3) @(posedge mclk);
        hw_trigger <= 1'b0;
        repeat (20) @(posedge mclk);
        reg_read(status_addr, d);  `CHK(d & 16'h003C, 16'h0004)
        `CHK(sampling, 1'b0)
        // dropping the comparator enable mid-conversion must stop as well
        reg_write(ctrl_addr, 16'h0003);
        wait_end(n);
        reg_write(ctrl_addr, 16'h0001);
        repeat (5) @(posedge mclk);
        reg_read(status_addr, d);  `CHK(d & 16'h003C, 16'h0004)
        $display("test trigger and stop done");

        // in stop the sticky end bit is stable, so mask and clear can be seen without a race
        `CHK(irq, 1'b1)
        reg_write(irq_enable_addr, 16'h0000);
        @(posedge mclk);           `CHK(irq, 1'b0)
        reg_write(irq_enable_addr, 16'h0003);
        @(posedge mclk);           `CHK(irq, 1'b1)
        reg_write(irq_clear_addr, 16'h0003);
        @(posedge mclk);           `CHK(irq, 1'b0)
        reg_read(status_addr, d);  `CHK(d & 16'h0003, 16'h0000)
        $display("test interrupt done");
        complete_run();
    end
endmodule
`default_nettype wire
